// *** src/pmhc_top.sv ***
/*
  Host controller for a two-wire pointing-device link: sends the enable
  command, receives three-slice movement reports, buffers them, and shows
  buttons on lights and accumulated X/Y on four hex digits.
  Assumes open-drain wires resolved outside, pulled up when released; push
  buttons active low; link clock made by the device, stopped when idle.

*/
`timescale 1ns/1ns
module pmhc_top
  import pmhc_pkg::*;
#(
  parameter int TX_TIMEOUT = TX_TIMEOUT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ps2_clk_i,
  output logic            ps2_clk_o,
  output logic            ps2_clk_oe,
  input  wire logic       ps2_dat_i,
  output logic            ps2_dat_o,
  output logic            ps2_dat_oe,
  input  wire logic       enable_key_n,
  input  wire logic       clear_key_n,
  input  wire logic       hold_switch,
  output logic            left_press_light,
  output logic            right_press_light,
  output logic            middle_press_light,
  output logic      [6:0] x_low_digit,
  output logic      [6:0] x_high_digit,
  output logic      [6:0] y_low_digit,
  output logic      [6:0] y_high_digit,
  output logic            fault_light,
  output logic            overflow_light
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREP,
    ST_INHIBIT,
    ST_WAIT,
    ST_FREE
  } pmhc_state_t;

  // system side
  pmhc_state_t             state_q;
  logic [SY_W-1:0]         s1_q;
  logic [SY_W-1:0]         s2_q;
  logic [SY_W-1:0]         s3_q;
  logic                    tx_req_q;
  logic [7:0]              tx_byte_q;
  logic                    tx_busy_q;
  logic                    clk_oe_q;
  logic                    en_pend_q;
  logic [31:0]             cnt_q;
  logic                    fault_q;
  logic                    ovf_q;
  logic [2:0]              btn_q;
  logic [7:0]              x_q;
  logic [7:0]              y_q;
  logic [6:0]              xl_q;
  logic [6:0]              xh_q;
  logic [6:0]              yl_q;
  logic [6:0]              yh_q;

  // link side
  logic                    tx_seen_q;
  logic                    tx_act_q;
  logic [3:0]              tx_edge_q;
  logic [8:0]              tx_sh_q;
  logic                    dat_low_q;
  logic                    done_tgl_q;
  logic                    ack_ok_q;
  logic                    skip_q;
  logic [5:0]              rx_cnt_q;
  logic [REPORT_BITS-1:0]  rx_sh_q;
  logic [REPORT_BITS-1:0]  rx_word_q;
  logic                    rx_tgl_q;

  logic                    tx_start;
  logic                    en_press;
  logic                    clr_press;
  logic                    rx_evt;
  logic                    done_evt;
  logic                    clk_fall;
  logic                    word_ok;
  logic [FIFO_WIDTH-1:0]   word_data;
  logic                    push_ready;
  logic                    pop_valid;
  logic [FIFO_WIDTH-1:0]   pop_data;
  logic                    pop_ready;

  ////////////////////////////////////////////////////////////////////////////
  // pins: open-drain, value always low
  assign ps2_clk_o  = 1'b0;
  assign ps2_dat_o  = 1'b0;
  assign ps2_clk_oe = clk_oe_q;
  assign ps2_dat_oe = dat_low_q && tx_busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: host transmit, falling edges of the device clock
  // request word is held stable a cycle before our own inhibit edge
  assign tx_start = (tx_req_q != tx_seen_q);

  always_ff @(negedge ps2_clk_i or negedge nrst) begin
    if (!nrst) begin
      tx_seen_q  <= 1'b0;
      tx_act_q   <= 1'b0;
      tx_edge_q  <= 4'h0;
      tx_sh_q    <= 9'h000;
      dat_low_q  <= 1'b0;
      done_tgl_q <= 1'b0;
      ack_ok_q   <= 1'b0;
    end else if (tx_start) begin
      // inhibit edge: arm and pull data low as start bit
      tx_seen_q  <= tx_req_q;
      tx_act_q   <= 1'b1;
      tx_edge_q  <= 4'h0;
      tx_sh_q    <= {~^tx_byte_q, tx_byte_q};
      dat_low_q  <= 1'b1;
    end else if (tx_act_q) begin
      tx_edge_q <= tx_edge_q + 4'h1;
      if (tx_edge_q <= TX_LAST_DRIVE) begin
        dat_low_q <= ~tx_sh_q[0];
        tx_sh_q   <= {1'b0, tx_sh_q[8:1]};
      end else if (tx_edge_q == TX_RELEASE) begin
        dat_low_q <= 1'b0;
      end else begin
        ack_ok_q   <= ~ps2_dat_i;
        done_tgl_q <= ~done_tgl_q;
        tx_act_q   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: receive shift register
  always_ff @(negedge ps2_clk_i or negedge nrst) begin
    if (!nrst) begin
      rx_cnt_q  <= 6'h00;
      rx_sh_q   <= '0;
      rx_word_q <= '0;
      rx_tgl_q  <= 1'b0;
      skip_q    <= 1'b0;
    end else if (tx_start) begin
      // inhibit aborts a frame in progress
      rx_cnt_q <= 6'h00;
    end else if (tx_act_q) begin
      // the device answers the command with one slice; drop it
      skip_q   <= (tx_edge_q == TX_ACK_EDGE) || skip_q;
      rx_cnt_q <= 6'h00;
    end else begin
      rx_sh_q  <= {ps2_dat_i, rx_sh_q[REPORT_BITS-1:1]};
      rx_cnt_q <= rx_cnt_q + 6'h01;
      if (skip_q && rx_cnt_q == RX_SLICE_LAST) begin
        rx_cnt_q <= 6'h00;
        skip_q   <= 1'b0;
      end else if (rx_cnt_q == RX_LAST_BIT) begin
        rx_word_q <= {ps2_dat_i, rx_sh_q[REPORT_BITS-1:1]};
        rx_tgl_q  <= ~rx_tgl_q;
        rx_cnt_q  <= 6'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: wires, buttons and toggles from the link domain
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s1_q <= SY_RST;
      s2_q <= SY_RST;
      s3_q <= SY_RST;
    end else begin
      s1_q <= {done_tgl_q, rx_tgl_q, hold_switch, clear_key_n, enable_key_n, ps2_dat_i, ps2_clk_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // idle reset levels, so no false edge follows release
  assign en_press  = s3_q[SY_EN] && !s2_q[SY_EN];
  assign clr_press = s3_q[SY_CLR] && !s2_q[SY_CLR];
  assign rx_evt    = (s3_q[SY_RXT] != s2_q[SY_RXT]) && state_q != ST_PREP;
  assign done_evt  = s3_q[SY_DONE] != s2_q[SY_DONE];
  assign clk_fall  = s3_q[SY_CLK] && !s2_q[SY_CLK];

  ////////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      en_pend_q <= 1'b0;
    end else if (en_press) begin
      en_pend_q <= 1'b1;
    end else if (state_q == ST_IDLE && !clk_fall) begin
      en_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q   <= ST_IDLE;
      tx_req_q  <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_busy_q <= 1'b0;
      clk_oe_q  <= 1'b0;
      cnt_q     <= 32'h0000_0000;
      fault_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (en_pend_q && !clk_fall) begin
            tx_byte_q <= CMD_ENABLE;
            tx_req_q  <= ~tx_req_q;
            tx_busy_q <= 1'b1;
            state_q   <= ST_PREP;
          end
        end
        ST_PREP: begin
          clk_oe_q <= 1'b1;
          cnt_q    <= 32'h0000_0000;
          state_q  <= ST_INHIBIT;
        end
        ST_INHIBIT: begin
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_q == 32'(INHIBIT_CYC - 1)) begin
            clk_oe_q <= 1'b0;
            cnt_q    <= 32'h0000_0000;
            state_q  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt_q <= cnt_q + 32'h0000_0001;
          if (done_evt) begin
            fault_q <= ~ack_ok_q;
            state_q <= ST_FREE;
          end else if (cnt_q == 32'(TX_TIMEOUT - 1)) begin
            fault_q   <= 1'b1;
            tx_busy_q <= 1'b0;
            state_q   <= ST_IDLE;
          end
        end
        ST_FREE: begin
          if (s2_q[SY_CLK] && s2_q[SY_DAT]) begin
            tx_busy_q <= 1'b0;
            state_q   <= ST_IDLE;
          end
        end
        default: begin
          clk_oe_q  <= 1'b0;
          tx_busy_q <= 1'b0;
          state_q   <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // report check: start, parity, stop per slice
  always_comb begin
    word_ok   = 1'b1;
    word_data = '0;
    for (int k = 0; k < SLICES; k++) begin
      word_ok = word_ok && !rx_word_q[k*SLICE_BITS + SL_START];
      word_ok = word_ok && rx_word_q[k*SLICE_BITS + SL_STOP];
      word_ok = word_ok && (^rx_word_q[k*SLICE_BITS + SL_DATA_LSB +: 9]);
      word_data[k*8 +: 8] = rx_word_q[k*SLICE_BITS + SL_DATA_LSB +: 8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ovf_q <= 1'b0;
    end else if (rx_evt && word_ok && !push_ready) begin
      ovf_q <= 1'b1;
    end else if (clr_press) begin
      ovf_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // report buffer; the hold switch stalls the drain side
  pmhc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .nrst      (nrst),
    .in_valid  (rx_evt && word_ok),
    .in_ready  (push_ready),
    .in_data   (word_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  assign pop_ready = !s2_q[SY_HOLD];

  ////////////////////////////////////////////////////////////////////////////
  // buttons and displacement cache
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      btn_q <= 3'h0;
    end else if (pop_valid && pop_ready) begin
      btn_q <= {pop_data[BTN_MIDDLE], pop_data[BTN_RIGHT], pop_data[BTN_LEFT]};
    end
  end

  // clear with a report in the same cycle keeps that report's motion
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      x_q <= POS_RST;
      y_q <= POS_RST;
    end else if (clr_press) begin
      x_q <= (pop_valid && pop_ready) ? pop_data[15:8] : POS_RST;
      y_q <= (pop_valid && pop_ready) ? pop_data[23:16] : POS_RST;
    end else if (pop_valid && pop_ready) begin
      x_q <= x_q + pop_data[15:8];
      y_q <= y_q + pop_data[23:16];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      xl_q <= SEG_RST;
      xh_q <= SEG_RST;
      yl_q <= SEG_RST;
      yh_q <= SEG_RST;
    end else begin
      xl_q <= pmhc_seg(x_q[3:0]);
      xh_q <= pmhc_seg(x_q[7:4]);
      yl_q <= pmhc_seg(y_q[3:0]);
      yh_q <= pmhc_seg(y_q[7:4]);
    end
  end

  assign left_press_light   = btn_q[0];
  assign right_press_light  = btn_q[1];
  assign middle_press_light = btn_q[2];
  assign x_low_digit        = xl_q;
  assign x_high_digit       = xh_q;
  assign y_low_digit        = yl_q;
  assign y_high_digit       = yh_q;
  assign fault_light        = fault_q;
  assign overflow_light     = ovf_q;

endmodule : pmhc_top

// *** src/pmhc_pkg.sv ***
/*
  Shared constants and helpers for the pointing-device link host controller:
  timing counts, protocol field positions, reset values and digit patterns.
  Assumes a 10 MHz system clock; the link clock comes from the pointing device.
*/
package pmhc_pkg;

  // system clock
  localparam int CLK_MHZ          = 10;

  // inhibit hold: well over one link clock period
  localparam int INHIBIT_TIME_US  = 100;
  localparam int INHIBIT_CYC      = INHIBIT_TIME_US * CLK_MHZ;

  // give-up time for a host transfer (device must start clocking within 10 ms)
  localparam int TX_TIMEOUT_MS    = 20;
  localparam int TX_TIMEOUT_CYC   = TX_TIMEOUT_MS * 1000 * CLK_MHZ;

  // frame layout
  localparam int REPORT_BITS      = 33;
  localparam int SLICE_BITS       = 11;
  localparam int SLICES           = 3;
  localparam int SL_START         = 0;
  localparam int SL_DATA_LSB      = 1;
  localparam int SL_PARITY        = 9;
  localparam int SL_STOP          = 10;
  localparam logic [5:0] RX_LAST_BIT   = 6'h20;
  localparam logic [5:0] RX_SLICE_LAST = 6'h0A;

  // host-to-device edge numbering, counted from the first device falling edge
  localparam logic [3:0] TX_LAST_DRIVE = 4'h8;
  localparam logic [3:0] TX_RELEASE    = 4'h9;
  localparam logic [3:0] TX_ACK_EDGE   = 4'hA;

  // enable data reporting command
  localparam logic [7:0] CMD_ENABLE    = 8'hF4;

  // button positions in the first report byte
  localparam int BTN_LEFT         = 0;
  localparam int BTN_RIGHT        = 1;
  localparam int BTN_MIDDLE       = 2;

  // report buffer
  localparam int FIFO_WIDTH       = 24;
  localparam int FIFO_DEPTH       = 32;

  // synchroniser lanes
  localparam int SY_CLK           = 0;
  localparam int SY_DAT           = 1;
  localparam int SY_EN            = 2;
  localparam int SY_CLR           = 3;
  localparam int SY_HOLD          = 4;
  localparam int SY_RXT           = 5;
  localparam int SY_DONE          = 6;
  localparam int SY_W             = 7;

  // reset values
  localparam logic [7:0] POS_RST       = 8'h00;
  localparam logic [6:0] SEG_RST       = 7'h3F;
  // synchroniser lanes at their idle levels: wires and keys high, switch and toggles low
  localparam logic [SY_W-1:0] SY_RST   = 7'h0F;

  // hex digit to segments, bit order gfedcba, active high
  function automatic logic [6:0] pmhc_seg(input logic [3:0] v);
    logic [6:0] s;
    s = 7'h00;
    case (v)
      4'h0: s = 7'h3F;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5B;
      4'h3: s = 7'h4F;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6D;
      4'h6: s = 7'h7D;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h6F;
      4'hA: s = 7'h77;
      4'hB: s = 7'h7C;
      4'hC: s = 7'h39;
      4'hD: s = 7'h5E;
      4'hE: s = 7'h79;
      default: s = 7'h71;
    endcase
    return s;
  endfunction : pmhc_seg

endpackage : pmhc_pkg

// *** src/pmhc_fifo.sv ***
/*
  Flip-flop FIFO with valid/ready on both sides, single clock.
  Assumes a synchronous active-low reset on the same clock.
*/
`timescale 1ns/1ns
module pmhc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end

endmodule : pmhc_fifo

// *** verif/pmhc_monitor.sv ***
/*
  Port-level checker for the pointing-device link host controller.
  Assumes the top module's port names; bound to every pmhc_top instance.
*/
`timescale 1ns/1ns
module pmhc_monitor
  import pmhc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       ps2_clk_o,
  input wire logic       ps2_clk_oe,
  input wire logic       ps2_dat_o,
  input wire logic       ps2_dat_oe,
  input wire logic       clear_key_n,
  input wire logic       hold_switch,
  input wire logic       left_press_light,
  input wire logic       right_press_light,
  input wire logic       middle_press_light,
  input wire logic [6:0] x_low_digit,
  input wire logic [6:0] x_high_digit,
  input wire logic [6:0] y_low_digit,
  input wire logic [6:0] y_high_digit,
  input wire logic       fault_light,
  input wire logic       overflow_light
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic [10:0] inh_q;
  logic [2:0]  lights;
  logic [27:0] digits;
  assign lights = {middle_press_light, right_press_light, left_press_light};
  assign digits = {x_high_digit, x_low_digit, y_high_digit, y_low_digit};

  // consecutive inhibit cycles so far
  always_ff @(posedge ref_clk) begin
    if (!nrst) inh_q <= 11'h000;
    else if (ps2_clk_oe) inh_q <= inh_q + 11'h001;
    else inh_q <= 11'h000;
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_open_drain; ps2_clk_o == 1'b0 && ps2_dat_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("wire driven high");
  property p_inh_len; $fell(ps2_clk_oe) |-> inh_q == INHIBIT_CYC; endproperty
  a_inh_len: assert property (p_inh_len) else $error("inhibit length wrong");
  property p_inh_max; ps2_clk_oe |-> inh_q < INHIBIT_CYC; endproperty
  a_inh_max: assert property (p_inh_max) else $error("inhibit too long");
  property p_request; $fell(ps2_clk_oe) |-> ps2_dat_oe; endproperty
  a_request: assert property (p_request) else $error("clock released without data low");
  property p_reset_vals;
    $rose(nrst) |-> !ps2_clk_oe && !ps2_dat_oe && !fault_light && !overflow_light && lights == 3'h0
      && x_low_digit == SEG_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad state after reset");
  property p_clear; (!clear_key_n && hold_switch)[*8] |=> digits == {4{SEG_RST}} && !overflow_light; endproperty
  a_clear: assert property (p_clear) else $error("clear did not empty cache");
  property p_ovf_sticky; (overflow_light && clear_key_n)[*5] |=> overflow_light; endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped without clear");
  property p_frozen; hold_switch[*6] |=> $stable(lights); endproperty
  a_frozen: assert property (p_frozen) else $error("lights moved while held");
endmodule : pmhc_monitor

bind pmhc_top pmhc_monitor u_mon (.*);

// *** verif/pmhc_mouse.sv ***
/*
  Behavioural pointing device: answers host requests and sends reports.
  Assumes wires pulled up; drives only low; clock stands still between frames.
*/
`timescale 1ns/1ns
module pmhc_mouse (
  input  wire logic clk_w,
  input  wire logic dat_w,
  input  wire logic ack_en,
  output logic      clk_low,
  output logic      dat_low
);
  localparam int HALF = 80;
  logic [10:0] rx_q;
  int          rx_cnt;
  time         inh_ns;
  time         t0;
  logic        busy;
  logic        enabled;
  logic        mute;
  initial begin
    clk_low = 1'b0;
    dat_low = 1'b0;
    busy = 1'b0;
    enabled = 1'b0;
    mute = 1'b0;
    rx_cnt = 0;
  end

  // one slice: start, data lsb first, odd parity, stop
  task automatic send_slice(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    for (int j = 0; j < 11; j++) begin
      dat_low = ~f[j];
      #HALF clk_low = 1'b1;
      #HALF clk_low = 1'b0;
    end
    dat_low = 1'b0;
    #HALF;
  endtask : send_slice

  task automatic send_report(input logic [7:0] b0, input logic [7:0] x, input logic [7:0] y, input logic bad);
    if (enabled) begin
      busy = 1'b1;
      send_slice(b0, 1'b0);
      send_slice(x, bad);
      send_slice(y, 1'b0);
      busy = 1'b0;
    end
  endtask : send_report

  always begin : host_request
    @(negedge clk_w);
    t0 = $time;
    if (!busy) begin
      @(posedge clk_w);
      inh_ns = $time - t0;
      if (!dat_w && !mute) begin
        busy = 1'b1;
        #50000;
        for (int i = 1; i < 12; i++) begin
          if (i == 11) dat_low = ack_en;
          #HALF clk_low = 1'b1;
          #HALF clk_low = 1'b0;
          if (i < 11) rx_q[i-1] = dat_w;
        end
        #HALF dat_low = 1'b0;
        rx_cnt++;
        if (ack_en && rx_q[7:0] == 8'hF4) enabled = 1'b1;
        if (ack_en) send_slice(8'hFA, 1'b0);
        busy = 1'b0;
      end
    end
  end
endmodule : pmhc_mouse

// *** verif/ps2_mouse_host_controller_bench.sv ***
/*
  Self-checking bench for the pointing-device link host controller.
  Assumes the behavioural device model and pulled-up open-drain wires.
*/
`timescale 1ns/1ns
module ps2_mouse_host_controller_bench;
  logic       ref_clk, nrst, enable_key_n, clear_key_n, hold_switch, ack_en;
  logic       ps2_clk_o, ps2_clk_oe, ps2_dat_o, ps2_dat_oe, m_clk_low, m_dat_low;
  logic       left_press_light, right_press_light, middle_press_light, fault_light, overflow_light;
  logic [6:0] x_low_digit, x_high_digit, y_low_digit, y_high_digit;
  logic       clk_w, dat_w;
  int         fails, checks, cycles;
  logic [6:0] seg_tbl [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                               7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};

  assign clk_w = (ps2_clk_oe ? ps2_clk_o : 1'b1) & ~m_clk_low;
  assign dat_w = (ps2_dat_oe ? ps2_dat_o : 1'b1) & ~m_dat_low;

  pmhc_top #(.TX_TIMEOUT(2000)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .ps2_clk_i(clk_w), .ps2_clk_o(ps2_clk_o), .ps2_clk_oe(ps2_clk_oe),
    .ps2_dat_i(dat_w), .ps2_dat_o(ps2_dat_o), .ps2_dat_oe(ps2_dat_oe), .enable_key_n(enable_key_n),
    .clear_key_n(clear_key_n), .hold_switch(hold_switch), .left_press_light(left_press_light),
    .right_press_light(right_press_light), .middle_press_light(middle_press_light),
    .x_low_digit(x_low_digit), .x_high_digit(x_high_digit), .y_low_digit(y_low_digit),
    .y_high_digit(y_high_digit), .fault_light(fault_light), .overflow_light(overflow_light));
  pmhc_mouse u_mouse (.clk_w(clk_w), .dat_w(dat_w), .ack_en(ack_en), .clk_low(m_clk_low), .dat_low(m_dat_low));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : cyc

  task automatic disp(input logic [7:0] x, input logic [7:0] y);
    chk({x_high_digit, x_low_digit, y_high_digit, y_low_digit},
        {seg_tbl[x[7:4]], seg_tbl[x[3:0]], seg_tbl[y[7:4]], seg_tbl[y[3:0]]});
  endtask : disp

  task automatic press(input logic clr);
    if (clr) clear_key_n = 1'b0;
    else enable_key_n = 1'b0;
    cyc(10);
    clear_key_n = 1'b1;
    enable_key_n = 1'b1;
    cyc(10);
  endtask : press

  task automatic send(input logic [7:0] b0, input logic [7:0] x, input logic [7:0] y, input logic bad);
    u_mouse.send_report(b0, x, y, bad);
    cyc(20);
  endtask : send

  task automatic wait_rx(input int n);
    for (int i = 0; i < 20000 && u_mouse.rx_cnt < n; i++) cyc(1);
    cyc(300);
  endtask : wait_rx

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({left_press_light, right_press_light, middle_press_light}, 3'h0);
    disp(8'h00, 8'h00);
    chk({fault_light, overflow_light, ps2_clk_oe, ps2_dat_oe}, 4'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_enable();
    press(1'b0);
    wait_rx(1);
    chk(u_mouse.rx_q[7:0], 8'hF4);
    chk(^u_mouse.rx_q[8:0], 1'b1);
    chk(u_mouse.rx_q[9], 1'b1);
    chk(u_mouse.inh_ns > 160, 1'b1);
    chk(fault_light, 1'b0);
    $display("test enable done");
  endtask : t_enable

  task automatic t_mute();
    u_mouse.mute = 1'b1;
    press(1'b0);
    cyc(3050);
    chk({fault_light, ps2_clk_oe, ps2_dat_oe}, 3'h4);
    u_mouse.mute = 1'b0;
    $display("test mute done");
  endtask : t_mute

  task automatic t_report();
    send(8'h05, 8'h12, 8'h34, 1'b0);
    chk({middle_press_light, right_press_light, left_press_light}, 3'h5);
    disp(8'h12, 8'h34);
    send(8'h0A, 8'hF0, 8'h01, 1'b0);
    chk({middle_press_light, right_press_light, left_press_light}, 3'h2);
    disp(8'h02, 8'h35);
    send(8'h07, 8'h11, 8'h11, 1'b1);
    chk({middle_press_light, right_press_light, left_press_light}, 3'h2);
    disp(8'h02, 8'h35);
    $display("test report done");
  endtask : t_report

  task automatic t_fifo();
    hold_switch = 1'b1;
    press(1'b1);
    disp(8'h00, 8'h00);
    for (int i = 0; i < 33; i++) send(8'h08, 8'h01, 8'h02, 1'b0);
    chk(overflow_light, 1'b1);
    disp(8'h00, 8'h00);
    hold_switch = 1'b0;
    cyc(100);
    disp(8'h20, 8'h40);
    press(1'b1);
    chk(overflow_light, 1'b0);
    disp(8'h00, 8'h00);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_nak();
    ack_en = 1'b0;
    press(1'b0);
    wait_rx(2);
    chk(fault_light, 1'b1);
    $display("test nak done");
  endtask : t_nak

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    nrst = 1'b1;
    enable_key_n = 1'b1;
    clear_key_n = 1'b1;
    hold_switch = 1'b0;
    ack_en = 1'b1;
    fails = 0;
    checks = 0;
    cycles = 0;
    // a real falling edge, so the link-domain flops clear
    #5;
    nrst = 1'b0;
    cyc(10);
    nrst = 1'b1;
    cyc(5);
    t_reset();
    t_mute();
    t_enable();
    t_report();
    t_fifo();
    t_nak();
    conclude();
  end
endmodule : ps2_mouse_host_controller_bench
